/* hw/interval_pwm_timer.sv */
// 8-bit interval / PWM timer with port 1 direction and carrier status bits
`timescale 1ns/1ps
module interval_pwm_timer
  import pwm_timer_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  // Memory-mapped byte access
  input  wire logic [15:0]  addr_i,
  input  wire logic         wr_en_i,
  input  wire logic         rd_en_i,
  input  wire logic [7:0]   wdata_i,
  output logic      [7:0]   rdata_o,
  // Slow count source for select codes 5 to 7, and carrier transfer strobe
  input  wire logic         ext_tick_i,
  input  wire logic         carrier_xfer_i,
  // Match interrupt and port 1 pins
  output logic              match_irq_o,
  output logic      [7:0]   port1_o,
  output logic      [7:0]   port1_oe_o
);

  // The compare registers and the byte bus only fit an 8-bit counter
  if (CNT_W != 8)
  begin : g_width_check
    $error("interval_pwm_timer: only an 8-bit counter is supported");
  end

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0]            mode_q;
  logic [7:0]            period_q;
  logic [7:0]            duty_q;
  logic [7:0]            duty_buf_q;
  logic                  duty_pend_q;
  logic [1:0]            duty_age_q;
  logic [7:0]            dir_q;
  logic [7:0]            latch_q;
  logic                  remote_q;
  logic                  car_buf_q;
  logic                  car_flag_q;
  logic [CNT_W-1:0]      cnt_q;
  logic                  started_q;
  logic                  tout_q;
  cmp_sel_t              sel_q;
  logic [PRESCALE_W-1:0] pre_q;

  logic       run;
  logic       idle_lvl;
  logic       gate;
  logic       is_pwm;
  logic       tick;
  logic       wr_mode;
  logic       wr_duty;
  logic       wr_car;
  logic       per_hit;
  logic       duty_hit;

  assign run      = mode_q[MODE_RUN_BIT];
  assign idle_lvl = mode_q[MODE_IDLE_BIT];
  assign gate     = mode_q[MODE_GATE_BIT];
  assign is_pwm   = (mode_q[MODE_MD_LSB +: 2] == MD_PWM);
  assign wr_mode  = wr_en_i && (addr_i == ADDR_MODE);
  assign wr_duty  = wr_en_i && (addr_i == ADDR_DUTY);
  assign wr_car   = wr_en_i && (addr_i == ADDR_CARRIER);

  // True when every bit below the given shift of the prescaler is one
  function automatic logic pre_full(input logic [PRESCALE_W-1:0] p, input int sh);
    logic [PRESCALE_W-1:0] m;
    m = PRESCALE_W'((1 << sh) - 1);
    return (p & m) == m;
  endfunction

  // ****************************************
  // Count clock selection
  // ****************************************
  // Free-running prescaler; the slowest taps come from the slow source input
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end

  always_comb
  begin
    case (mode_q[MODE_CKS_LSB +: 3])
      3'h0:    tick = 1'b1;
      3'h1:    tick = pre_full(pre_q, 2);
      3'h2:    tick = pre_full(pre_q, 4);
      3'h3:    tick = pre_full(pre_q, 6);
      3'h4:    tick = pre_full(pre_q, 12);
      default: tick = ext_tick_i;
    endcase
  end

  // Compare hits are only meaningful on a counting tick
  assign per_hit  = run && tick && started_q && (sel_q == CMP_PERIOD || !is_pwm) && (cnt_q == period_q);
  assign duty_hit = run && tick && started_q && is_pwm && (sel_q == CMP_DUTY) && (cnt_q == duty_q);

  // ****************************************
  // Register writes
  // ****************************************
  // mode bits steer idle level, gate, clock and run
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_q   <= RST_ZERO;
      period_q <= RST_ZERO;
      latch_q  <= RST_ZERO;
    end
    else if (wr_en_i)
    begin
      if (addr_i == ADDR_MODE)
        mode_q <= wdata_i;
      if (addr_i == ADDR_PERIOD)
        period_q <= wdata_i;
      if (addr_i == ADDR_PORT1)
        latch_q <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      dir_q <= RST_DIR1;
    else if (wr_en_i && addr_i == ADDR_DIR1)
      dir_q <= wdata_i;
  end

  // flag bit only moves on the transfer strobe
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      remote_q   <= 1'b0;
      car_buf_q  <= 1'b0;
      car_flag_q <= 1'b0;
    end
    else
    begin
      if (wr_car)
      begin
        remote_q  <= wdata_i[CAR_REMOTE_BIT];
        car_buf_q <= wdata_i[CAR_BUFFER_BIT];
      end
      // flag mirrors the enabled state taken from the buffer
      if (carrier_xfer_i)
        car_flag_q <= car_buf_q;
    end
  end

  // ****************************************
  // Duty register with write buffer
  // ****************************************
  // While stopped a write lands directly; while running it waits for the old match
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      duty_q      <= RST_ZERO;
      duty_buf_q  <= RST_ZERO;
      duty_pend_q <= 1'b0;
      duty_age_q  <= 2'h0;
    end
    else if (wr_duty)
    begin
      duty_buf_q <= wdata_i;
      duty_age_q <= 2'h0;
      if (run)
        duty_pend_q <= 1'b1;
      else
      begin
        duty_q      <= wdata_i;
        duty_pend_q <= 1'b0;
      end
    end
    else
    begin
      if (run && tick && duty_age_q != DUTY_XFER_TICKS)
        duty_age_q <= duty_age_q + 2'h1;
      // too young a value waits for the next match
      if (duty_hit && duty_pend_q && duty_age_q == DUTY_XFER_TICKS)
      begin
        duty_q      <= duty_buf_q;
        duty_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Counter and compare sequencing
  // ****************************************
  // stop clears the counter; start counts on the next count clock in interval mode, on the one after in PWM
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_q     <= '0;
      started_q <= 1'b0;
      sel_q     <= CMP_PERIOD;
    end
    else if (!run)
    begin
      cnt_q     <= '0;
      started_q <= 1'b0;
      sel_q     <= CMP_PERIOD;
    end
    else if (tick)
    begin
      // PWM masks the first count clock
      if (!started_q && is_pwm)
        started_q <= 1'b1;
      else if (per_hit)
      begin
        started_q <= 1'b1;
        cnt_q     <= '0;
        // next compare is the duty register in PWM, the period register in interval mode
        sel_q     <= is_pwm ? CMP_DUTY : CMP_PERIOD;
      end
      else
      begin
        // interval counts on the first tick
        started_q <= 1'b1;
        cnt_q     <= cnt_q + 1'b1;
        // duty match keeps counting, back to period compare
        if (duty_hit)
          sel_q <= CMP_PERIOD;
      end
    end
  end

  // ****************************************
  // Interrupt and timer output
  // ****************************************
  // interrupt pulse one clock after the match tick; N+1 ticks apart
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      match_irq_o <= 1'b0;
    else
      match_irq_o <= per_hit;
  end

  // stop or disabled gate forces default level
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      tout_q <= 1'b0;
    // a PWM stop also lands on idle, the inactive level
    else if (!run || !gate)
      tout_q <= idle_lvl;
    // active level is the inverse of idle, M+1 of N+1 ticks
    else if (is_pwm && per_hit)
      tout_q <= !idle_lvl;
    else if (is_pwm && duty_hit)
      tout_q <= idle_lvl;
    else if (!is_pwm && per_hit)
      tout_q <= !tout_q;
  end

  // ****************************************
  // Port pins and read data
  // ****************************************
  // output buffer on where direction bit is 0; timer ORs into its pin
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      port1_o    <= RST_ZERO;
      port1_oe_o <= RST_ZERO;
    end
    else
    begin
      port1_o             <= latch_q;
      port1_o[TIMER_PIN]  <= latch_q[TIMER_PIN] | tout_q;
      port1_oe_o          <= ~dir_q;
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= RST_ZERO;
    else if (rd_en_i)
    begin
      case (addr_i)
        ADDR_MODE:    rdata_o <= mode_q;
        ADDR_PERIOD:  rdata_o <= period_q;
        ADDR_DUTY:    rdata_o <= duty_q;
        ADDR_DIR1:    rdata_o <= dir_q;
        ADDR_PORT1:   rdata_o <= latch_q;
        ADDR_CARRIER: rdata_o <= {5'h00, remote_q, car_buf_q, car_flag_q};
        default:      rdata_o <= RST_ZERO;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_stop_default;
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(run) |=> (cnt_q == '0) && !match_irq_o && (tout_q == $past(idle_lvl));
  endproperty
  a_stop_default: assert property (p_stop_default) else $error("stop did not restore defaults");

  property p_irq_cause;
    @(posedge ref_clk_i) disable iff (rst_i)
    match_irq_o |-> $past(run) && $past(tick) && ($past(cnt_q) == $past(period_q));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without period match");

  property p_interval_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
    (run && !is_pwm && per_hit && !wr_mode) |=> (cnt_q == '0) && match_irq_o;
  endproperty
  a_interval_clear: assert property (p_interval_clear) else $error("interval match did not clear");

  property p_interval_toggle;
    @(posedge ref_clk_i) disable iff (rst_i)
    (run && gate && !is_pwm && !wr_mode && $past(run) && $stable(mode_q) && $changed(tout_q)) |-> match_irq_o;
  endproperty
  a_interval_toggle: assert property (p_interval_toggle) else $error("interval output moved off match");

  property p_pwm_active;
    @(posedge ref_clk_i) disable iff (rst_i)
    (is_pwm && gate && per_hit && !wr_mode) |=> match_irq_o && (tout_q == !idle_lvl) && (sel_q == CMP_DUTY);
  endproperty
  a_pwm_active: assert property (p_pwm_active) else $error("PWM period match wrong");

  property p_pwm_inactive;
    @(posedge ref_clk_i) disable iff (rst_i)
    (gate && duty_hit && !wr_mode) |=> !match_irq_o && (tout_q == idle_lvl) && (cnt_q != '0);
  endproperty
  a_pwm_inactive: assert property (p_pwm_inactive) else $error("PWM duty match wrong");

  property p_flag_ro;
    @(posedge ref_clk_i) disable iff (rst_i)
    (wr_car && !carrier_xfer_i) |=> $stable(car_flag_q);
  endproperty
  a_flag_ro: assert property (p_flag_ro) else $error("carrier flag changed by a write");

  property p_young_duty;
    @(posedge ref_clk_i) disable iff (rst_i)
    (duty_hit && duty_pend_q && duty_age_q < DUTY_XFER_TICKS && !wr_duty) |=> duty_pend_q && $stable(duty_q);
  endproperty
  a_young_duty: assert property (p_young_duty) else $error("duty loaded too early");

  property p_dir_oe;
    @(posedge ref_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> port1_oe_o == ~$past(dir_q);
  endproperty
  a_dir_oe: assert property (p_dir_oe) else $error("pin enable does not follow direction");

endmodule

/* hw/pwm_timer_pkg.sv */
// Constants shared by the 8-bit interval and PWM timer
package pwm_timer_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [15:0] ADDR_PERIOD  = 16'hFF1A;
  localparam logic [15:0] ADDR_DUTY    = 16'hFF1B;
  localparam logic [15:0] ADDR_PORT1   = 16'hFF01;
  localparam logic [15:0] ADDR_DIR1    = 16'hFF21;
  localparam logic [15:0] ADDR_MODE    = 16'hFF6C;
  localparam logic [15:0] ADDR_CARRIER = 16'hFF6D;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_DIR1  = 8'hFF;
  localparam logic [7:0] RST_ZERO  = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int MODE_RUN_BIT    = 7;
  localparam int MODE_CKS_LSB    = 4;
  localparam int MODE_MD_LSB     = 2;
  localparam int MODE_IDLE_BIT   = 1;
  localparam int MODE_GATE_BIT   = 0;
  localparam int CAR_REMOTE_BIT  = 2;
  localparam int CAR_BUFFER_BIT  = 1;
  localparam int CAR_FLAG_BIT    = 0;
  localparam int TIMER_PIN       = 6;

  // ****************************************
  // Mode codes and timing counts
  // ****************************************
  localparam logic [1:0] MD_INTERVAL = 2'h0;
  localparam logic [1:0] MD_PWM      = 2'h2;
  localparam logic [1:0] DUTY_XFER_TICKS = 2'h3;
  localparam int PRESCALE_W = 12;

  // Compare selector in PWM mode
  typedef enum logic [1:0]
  {
    CMP_PERIOD = 2'b01,
    CMP_DUTY   = 2'b10
  } cmp_sel_t;

endpackage

/* verif/eight_bit_interval_pwm_timer_test.sv */
// Self-checking bench for the interval and PWM timer
`timescale 1ns/1ps
module eight_bit_interval_pwm_timer_test
  import pwm_timer_pkg::*;
;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        ref_clk_i      = 1'b0;
  logic        rst_i          = 1'b1;
  logic [15:0] addr_i         = 16'h0000;
  logic        wr_en_i        = 1'b0;
  logic        rd_en_i        = 1'b0;
  logic [7:0]  wdata_i        = 8'h00;
  logic        ext_tick_i     = 1'b0;
  logic        carrier_xfer_i = 1'b0;
  logic [1:0]  tick_div       = 2'h0;
  logic [7:0]  rdata_o;
  logic        match_irq_o;
  logic [7:0]  port1_o;
  logic [7:0]  port1_oe_o;
  logic        pin_level;
  logic [7:0]  irqs;
  logic [7:0]  highs;
  int          fail_count     = 0;
  int          comparisons    = 0;
  int          wait_n;

  interval_pwm_timer u_dut
  (
    .ref_clk_i      (ref_clk_i),
    .rst_i          (rst_i),
    .addr_i         (addr_i),
    .wr_en_i        (wr_en_i),
    .rd_en_i        (rd_en_i),
    .wdata_i        (wdata_i),
    .rdata_o        (rdata_o),
    .ext_tick_i     (ext_tick_i),
    .carrier_xfer_i (carrier_xfer_i),
    .match_irq_o    (match_irq_o),
    .port1_o        (port1_o),
    .port1_oe_o     (port1_oe_o)
  );

  pin_load u_load
  (
    .pin_i    (port1_o[TIMER_PIN]),
    .pin_oe_i (port1_oe_o[TIMER_PIN]),
    .level_o  (pin_level)
  );

  // 50 MHz clock
  always #10 ref_clk_i = ~ref_clk_i;

  // Slow count source, one pulse every third cycle
  always @(negedge ref_clk_i)
  begin
    tick_div   <= (tick_div == 2'h2) ? 2'h0 : tick_div + 2'h1;
    ext_tick_i <= (tick_div == 2'h2);
  end

  // ****************************************
  // Access and measurement tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_i  = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    @(negedge ref_clk_i);
    wr_en_i = 1'b0;
  endtask

  task automatic rd_check(input string what, input logic [15:0] a, input logic [7:0] exp);
    @(negedge ref_clk_i);
    addr_i  = a;
    rd_en_i = 1'b1;
    @(negedge ref_clk_i);
    rd_en_i = 1'b0;
    check(what, exp, rdata_o);
  endtask

  task automatic xfer;
    @(negedge ref_clk_i);
    carrier_xfer_i = 1'b1;
    @(negedge ref_clk_i);
    carrier_xfer_i = 1'b0;
  endtask

  // Bounded wait for a match pulse; counts pin high cycles meanwhile
  task automatic wait_irq(input int lim = 600);
    wait_n = 0;
    highs  = 8'h00;
    do
    begin
      @(negedge ref_clk_i);
      wait_n++;
      if (pin_level === 1'b1)
        highs++;
      if (wait_n > lim)
      begin
        fail_count++;
        $display("unexpected match wait: expected pulse, seen none");
        end_sim;
      end
    end
    while (match_irq_o !== 1'b1);
  endtask

  // Whole periods from a match, so the one-cycle pin lag cancels out
  task automatic measure(input int n);
    irqs  = 8'h00;
    highs = 8'h00;
    repeat (n)
    begin
      @(negedge ref_clk_i);
      if (match_irq_o === 1'b1)
        irqs++;
      if (pin_level === 1'b1)
        highs++;
    end
  endtask

  // Stop, let the pin lag settle, then expect silence at the given level
  task automatic stop_check(input logic [7:0] mode, input logic [7:0] lvl);
    wr_reg(ADDR_MODE, mode);
    repeat (3) @(negedge ref_clk_i);
    measure(10);
    check("irqs after stop", 8'h00, irqs);
    check("pin after stop", lvl, highs);
    rd_check("mode after stop", ADDR_MODE, mode);
  endtask

  // One interval run on a prescaler tap with N=1: count matches over whole periods, then stop
  task automatic tap_check(input string what, input logic [7:0] mode, input int n,
                           input logic [7:0] exp, input int lim);
    wr_reg(ADDR_MODE, mode);
    wait_irq(lim);
    measure(n);
    check(what, exp, irqs);
    stop_check(8'h01, 8'h00);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    @(negedge ref_clk_i);
    check("oe after reset", 8'h00, port1_oe_o);
    rd_check("direction", ADDR_DIR1, RST_DIR1);
    rd_check("carrier", ADDR_CARRIER, 8'h00);
    rd_check("unmapped", 16'hFF00, 8'h00);
    wr_reg(ADDR_CARRIER, 8'h07);
    rd_check("carrier bit0", ADDR_CARRIER, 8'h06);
    xfer();
    rd_check("carrier flag", ADDR_CARRIER, 8'h07);
    wr_reg(ADDR_CARRIER, 8'h00);
    xfer();
    rd_check("carrier off", ADDR_CARRIER, 8'h00);
    // Route the timer pins: latch and direction cleared
    wr_reg(ADDR_PORT1, 8'h00);
    wr_reg(ADDR_DIR1, 8'h9F);
    @(negedge ref_clk_i);
    check("oe routed", 8'h60, port1_oe_o);
    // Other latch bits reach their pins; timer pin 6 and pin 5 stay cleared
    wr_reg(ADDR_PORT1, 8'h81);
    @(negedge ref_clk_i);
    check("pins", 8'h81, port1_o);
    rd_check("latch", ADDR_PORT1, 8'h81);
    // Interval mode, N=3, duty value that must be ignored
    wr_reg(ADDR_PERIOD, 8'h03);
    wr_reg(ADDR_DUTY, 8'h01);
    rd_check("period", ADDR_PERIOD, 8'h03);
    wr_reg(ADDR_MODE, 8'h81);
    wait_irq();
    check("start delay ok", 8'h01, {7'h00, wait_n <= 6});
    measure(40);
    check("interval irqs", 8'h0A, irqs);
    check("square high", 8'h14, highs);
    stop_check(8'h01, 8'h00);
    // Slow count source, N=1, tick every 3 cycles
    wr_reg(ADDR_PERIOD, 8'h01);
    wr_reg(ADDR_MODE, 8'hD1);
    wait_irq();
    measure(36);
    check("ext irqs", 8'h06, irqs);
    stop_check(8'h01, 8'h00);
    // Prescaler taps /4, /16, /64 and /4096, two ticks per match
    tap_check("tap 4 irqs", 8'h91, 40, 8'h05, 600);
    tap_check("tap 16 irqs", 8'hA1, 64, 8'h02, 600);
    tap_check("tap 64 irqs", 8'hB1, 256, 8'h02, 600);
    tap_check("tap 4096 irqs", 8'hC1, 16384, 8'h02, 9000);
    // PWM, N=4, M=1, idle low
    wr_reg(ADDR_PERIOD, 8'h04);
    wr_reg(ADDR_DUTY, 8'h01);
    wr_reg(ADDR_MODE, 8'h89);
    wr_reg(ADDR_DUTY, 8'h01);
    wait_irq();
    check("pwm high before match", 8'h00, highs);
    measure(50);
    check("pwm irqs", 8'h0A, irqs);
    check("pwm high", 8'h14, highs);
    // Buffered duty written on the same tick as the old match: the write wins, so it does not load there
    wait_irq();
    wr_reg(ADDR_DUTY, 8'h02);
    rd_check("young duty", ADDR_DUTY, 8'h01);
    repeat (20) @(negedge ref_clk_i);
    wait_irq();
    measure(50);
    check("new duty high", 8'h1E, highs);
    rd_check("new duty", ADDR_DUTY, 8'h02);
    stop_check(8'h09, 8'h00);
    // Idle level high: stopped pin high, PWM active low
    stop_check(8'h0B, 8'h0A);
    wr_reg(ADDR_DUTY, 8'h01);
    wr_reg(ADDR_MODE, 8'h8B);
    wr_reg(ADDR_DUTY, 8'h01);
    wait_irq();
    measure(50);
    check("inverted high", 8'h1E, highs);
    stop_check(8'h08, 8'h00);
    end_sim();
  end
endmodule

/* verif/pin_load.sv */
// Board load on the timer output pin
`timescale 1ns/1ps
module pin_load
(
  // Pin as driven by the device
  input  wire logic pin_i,
  input  wire logic pin_oe_i,
  // Level seen on the board wire
  output logic      level_o
);
  // ****************************************
  // Wire level
  // ****************************************
  // Pull-down holds the wire low while the buffer is off, never a stale value
  assign level_o = pin_oe_i ? pin_i : 1'b0;
endmodule
